// ===== pcr_pkg.sv
package pcr_pkg;
	// Bus geometry
	localparam int          ADDR_W       = 8;
	localparam int          DATA_W       = 32;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	// Register byte offsets
	localparam logic [7:0]  OFF_P5_DIR   = 8'h00;
	localparam logic [7:0]  OFF_P6_DIR   = 8'h04;
	localparam logic [7:0]  OFF_P7_DIR   = 8'h08;
	localparam logic [7:0]  OFF_TA_CTL   = 8'h0C;
	localparam logic [7:0]  OFF_TBC_CTL  = 8'h10;
	localparam logic [7:0]  OFF_MOD_CTL  = 8'h14;
	localparam logic [7:0]  OFF_PD_CTL   = 8'h18;
	localparam logic [7:0]  OFF_OD_CTL   = 8'h1C;
	localparam logic [7:0]  OFF_PU_CTL   = 8'h20;
	localparam logic [7:0]  OFF_WDM_CTL  = 8'h24;
	localparam logic [7:0]  OFF_IMASK    = 8'h28;
	localparam logic [7:0]  OFF_FLAG     = 8'h2C;
	localparam logic [7:0]  OFF_FLAG2    = 8'h30;
	localparam logic [7:0]  OFF_GIE      = 8'h34;
	// Writable bits and bits that always read one
	localparam logic [7:0]  P5_DIR_WMASK = 8'h2F;
	localparam logic [7:0]  P6_DIR_WMASK = 8'h80;
	localparam logic [7:0]  TA_WMASK     = 8'h04;
	localparam logic [7:0]  TBC_WMASK    = 8'hC4;
	localparam logic [7:0]  PULL_WMASK   = 8'h2F;
	localparam logic [7:0]  PULL_FORCE   = 8'hD0;
	localparam logic [7:0]  OD_WMASK     = 8'h80;
	localparam logic [7:0]  OD_FORCE     = 8'h7F;
	localparam logic [7:0]  WDM_WMASK    = 8'hAF;
	localparam logic [7:0]  IMASK_WMASK  = 8'hFB;
	localparam logic [7:0]  FLAG_VALID   = 8'hFB;
	// Reset values
	localparam logic [7:0]  RST_ZERO     = 8'h00;
	localparam logic [7:0]  RST_PULL     = 8'hD0;
	localparam logic [7:0]  RST_OD       = 8'h7F;
	// Field positions
	localparam int          TA_RUN_B     = 2;
	localparam int          TB_UPPER_B   = 7;
	localparam int          TB_RUN_B     = 6;
	localparam int          TC_RUN_B     = 2;
	localparam int          TC_SCALE_B   = 7;
	localparam int          TC_SEL_LO    = 4;
	localparam int          MOD_ON_B     = 3;
	localparam int          MOD_CARR_B   = 2;
	localparam int          MOD_SINGLE_B = 1;
	localparam int          MOD_PINSEL_B = 0;
	localparam int          P67_B        = 7;
	localparam int          WD_ON_B      = 7;
	localparam int          CONV_IRQ_B   = 5;
	localparam int          WD_PRE_B     = 3;
	localparam int          WD_SEL_LO    = 0;
	// Rate code for a 1:1 rate
	localparam logic [3:0]  DIV_BYPASS   = 4'h0;
endpackage : pcr_pkg

// ===== irq_flag_bank.sv
`timescale 1ns/1ps
module irq_flag_bank #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	// Hardware events and software clear
	input  wire logic [WIDTH-1:0] event_set,
	input  wire logic             clr_wr,
	input  wire logic [WIDTH-1:0] clr_data,
	// Implemented bits and enables
	input  wire logic [WIDTH-1:0] valid_mask,
	input  wire logic [WIDTH-1:0] en_mask,
	// Flag state
	output logic      [WIDTH-1:0] flags,
	output logic      [WIDTH-1:0] masked
);
	// Width must fit one bus word
	if (WIDTH < 1 || WIDTH > 32) begin : g_chk
		$error("irq_flag_bank: WIDTH out of range");
	end

	logic [WIDTH-1:0] flags_reg; // Sticky flags

	// Writing 0 clears, writing 1 keeps; an event in the same cycle wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= ((flags_reg & (clr_wr ? clr_data : '1)) | event_set) & valid_mask;
		end
	end

	assign flags  = flags_reg;
	assign masked = flags_reg & en_mask;

	// A flag only rises from a hardware event
	property p_flag_cause;
		@(posedge core_clk) disable iff (!arst_n)
		(flags_reg & ~$past(flags_reg) & ~$past(event_set)) == '0;
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag set without event");

	// A clear without event leaves the bit low
	property p_flag_clear;
		@(posedge core_clk) disable iff (!arst_n)
		clr_wr |=> (flags_reg & ~$past(clr_data) & ~$past(event_set)) == '0;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");
endmodule : irq_flag_bank

// ===== peripheral_control_registers.sv
`timescale 1ns/1ps
module peripheral_control_registers #(
	parameter int ADDR_W = pcr_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              arst_n,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	// AXI4-Lite write data
	input  wire logic [pcr_pkg::DATA_W-1:0] wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	// AXI4-Lite write response
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	// AXI4-Lite read data
	output logic [pcr_pkg::DATA_W-1:0] rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Core instruction strobes
	input  wire logic              enable_irq_instr,
	input  wire logic              disable_irq_instr,
	input  wire logic              irq_taken,
	// Hardware interrupt events
	input  wire logic [7:0]        irq_events,
	input  wire logic              conversion_done_event,
	output logic                   irq_request,
	// Port directions
	output logic [7:0]             port5_dir,
	output logic [7:0]             port6_dir,
	output logic [7:0]             port7_dir,
	// Timer controls
	output logic                   timer_a_run,
	output logic                   timer_b_run,
	output logic                   timer_b_upper_byte_on,
	output logic                   timer_c_run,
	output logic [3:0]             timer_c_div_log2,
	output logic                   timer_c_carrier_clocked,
	// Modulator controls
	output logic                   modulator_on,
	output logic                   carrier_mode,
	output logic                   single_pulse_mode,
	input  wire logic              modulator_out,
	// Port 6 pin 7
	input  wire logic              port6_pin7_data,
	input  wire logic              port6_pin7_in,
	output logic                   port6_pin7_out,
	output logic                   port6_pin7_oe_n,
	output logic                   port6_pin7_level,
	// Pad configuration
	output logic [5:0]             pulldown_n_p5,
	output logic [5:0]             pullup_n_p5,
	output logic                   opendrain_n_p6_7,
	// Watchdog
	output logic                   watchdog_on,
	output logic [3:0]             watchdog_div_log2,
	output logic                   conversion_irq_on
);
	import pcr_pkg::*;

	// Offsets need at least six address bits
	if (ADDR_W < 6 || ADDR_W > 8) begin : g_chk
		$error("peripheral_control_registers: ADDR_W must be 6 to 8");
	end

	// Rate code: 0 for 1:1, else code+1 as log2 of the ratio
	function automatic logic [3:0] rate_log2(input logic on, input logic [2:0] sel);
		return on ? ({1'b0, sel} + 4'h1) : DIV_BYPASS;
	endfunction : rate_log2

	// Keep writable bits, force fixed ones
	function automatic logic [7:0] merge(input logic [7:0] d, input logic [7:0] m, input logic [7:0] f);
		return (d & m) | f;
	endfunction : merge

	// Bus state
	logic              aw_held;      // Write address captured
	logic [ADDR_W-1:0] aw_addr_reg;  // Captured write address
	logic              w_held;       // Write data captured
	logic [7:0]        w_data_reg;   // Captured low byte
	logic              w_strb0_reg;  // Captured lane 0 strobe
	logic              bvalid_reg;   // Write response pending
	logic [1:0]        bresp_reg;    // Write response code
	logic              rvalid_reg;   // Read data pending
	logic [7:0]        rdata_reg;    // Read byte
	logic [1:0]        rresp_reg;    // Read response code
	logic              do_write;     // Both halves held
	logic              wr_hit;       // Write address mapped
	logic              rd_hit;       // Read address mapped
	logic [7:0]        rd_byte;      // Read mux output
	logic [7:0]        aw_off;       // Write address as byte
	logic [7:0]        ar_off;       // Read address as byte
	// Control registers
	logic [7:0]        p5_dir_reg;
	logic [7:0]        p6_dir_reg;
	logic [7:0]        p7_dir_reg;
	logic [7:0]        ta_ctl_reg;
	logic [7:0]        tbc_ctl_reg;
	logic [7:0]        mod_ctl_reg;
	logic [7:0]        pd_ctl_reg;
	logic [7:0]        od_ctl_reg;
	logic [7:0]        pu_ctl_reg;
	logic [7:0]        wdm_ctl_reg;
	logic [7:0]        imask_reg;
	logic              gie_reg;      // Global interrupt enable
	logic              irq_req_reg;  // Registered request
	// Flags
	logic [7:0]        flags;        // Raw timer and pin flags
	logic [7:0]        masked_flags; // Flags gated by mask
	logic [0:0]        conv_flag;    // Raw conversion flag
	logic [0:0]        conv_masked;  // Conversion flag gated
	// Pin path
	logic              p67_meta;     // Synchroniser stage one
	logic              p67_sync;     // Synchroniser stage two
	logic              mod_level;    // Modulator level or idle high
	logic              pin_val;      // Selected pin value
	logic              pin_drive;    // Pin actively driven
	logic              pin_out_reg;
	logic              pin_oe_n_reg;

	assign aw_off = 8'(aw_addr_reg);
	assign ar_off = 8'(araddr);

	// Handshake outputs
	assign awready  = ~aw_held & ~bvalid_reg;
	assign wready   = ~w_held & ~bvalid_reg;
	assign arready  = ~rvalid_reg;
	assign do_write = aw_held & w_held & ~bvalid_reg;
	assign bvalid   = bvalid_reg;
	assign bresp    = bresp_reg;
	assign rvalid   = rvalid_reg;
	assign rresp    = rresp_reg;
	assign rdata    = {24'h0, rdata_reg};

	// Capture write address
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			aw_held     <= 1'b0;
			aw_addr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_held     <= 1'b1;
			aw_addr_reg <= awaddr;
		end else if (do_write) begin
			aw_held     <= 1'b0;
		end
	end

	// Capture write data
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			w_held      <= 1'b0;
			w_data_reg  <= RST_ZERO;
			w_strb0_reg <= 1'b0;
		end else if (wvalid && wready) begin
			w_held      <= 1'b1;
			w_data_reg  <= wdata[7:0];
			w_strb0_reg <= wstrb[0];
		end else if (do_write) begin
			w_held      <= 1'b0;
		end
	end

	// Write address decode
	always_comb begin
		unique case (aw_off)
			OFF_P5_DIR, OFF_P6_DIR, OFF_P7_DIR, OFF_TA_CTL, OFF_TBC_CTL, OFF_MOD_CTL,
			OFF_PD_CTL, OFF_OD_CTL, OFF_PU_CTL, OFF_WDM_CTL, OFF_IMASK, OFF_FLAG,
			OFF_FLAG2, OFF_GIE: wr_hit = 1'b1;
			default:            wr_hit = 1'b0;
		endcase
	end

	// Write enables, lane 0 carries the byte
	logic we;
	assign we = do_write & w_strb0_reg;

	// Write response, error on unmapped address
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Port direction registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			p5_dir_reg <= RST_ZERO;
			p6_dir_reg <= RST_ZERO;
			p7_dir_reg <= RST_ZERO;
		end else if (we) begin
			if (aw_off == OFF_P5_DIR) p5_dir_reg <= merge(w_data_reg, P5_DIR_WMASK, RST_ZERO);
			if (aw_off == OFF_P6_DIR) p6_dir_reg <= merge(w_data_reg, P6_DIR_WMASK, RST_ZERO);
			if (aw_off == OFF_P7_DIR) p7_dir_reg <= w_data_reg;
		end
	end

	// Timer and modulator control registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ta_ctl_reg  <= RST_ZERO;
			tbc_ctl_reg <= RST_ZERO;
			mod_ctl_reg <= RST_ZERO;
		end else if (we) begin
			if (aw_off == OFF_TA_CTL)  ta_ctl_reg  <= merge(w_data_reg, TA_WMASK, RST_ZERO);
			if (aw_off == OFF_TBC_CTL) tbc_ctl_reg <= merge(w_data_reg, TBC_WMASK, RST_ZERO);
			if (aw_off == OFF_MOD_CTL) mod_ctl_reg <= w_data_reg;
		end
	end

	// Pad configuration registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_ctl_reg <= RST_PULL;
			od_ctl_reg <= RST_OD;
			pu_ctl_reg <= RST_PULL;
		end else if (we) begin
			if (aw_off == OFF_PD_CTL) pd_ctl_reg <= merge(w_data_reg, PULL_WMASK, PULL_FORCE);
			if (aw_off == OFF_OD_CTL) od_ctl_reg <= merge(w_data_reg, OD_WMASK, OD_FORCE);
			if (aw_off == OFF_PU_CTL) pu_ctl_reg <= merge(w_data_reg, PULL_WMASK, PULL_FORCE);
		end
	end

	// Watchdog and mask registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wdm_ctl_reg <= RST_ZERO;
			imask_reg   <= RST_ZERO;
		end else if (we) begin
			if (aw_off == OFF_WDM_CTL) wdm_ctl_reg <= merge(w_data_reg, WDM_WMASK, RST_ZERO);
			if (aw_off == OFF_IMASK)   imask_reg   <= merge(w_data_reg, IMASK_WMASK, RST_ZERO);
		end
	end

	// Global enable: instruction set wins over any clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gie_reg <= 1'b0;
		end else if (enable_irq_instr) begin
			gie_reg <= 1'b1;
		end else if (disable_irq_instr || irq_taken) begin
			gie_reg <= 1'b0;
		end
	end

	// Timer, pin and modulator flags
	irq_flag_bank #(.WIDTH(8)) u_flags (
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.event_set  (irq_events),
		.clr_wr     (we && aw_off == OFF_FLAG),
		.clr_data   (w_data_reg),
		.valid_mask (FLAG_VALID),
		.en_mask    (imask_reg),
		.flags      (flags),
		.masked     (masked_flags)
	);

	// Conversion complete flag
	irq_flag_bank #(.WIDTH(1)) u_conv (
		.core_clk   (core_clk),
		.arst_n     (arst_n),
		.event_set  (conversion_done_event),
		.clr_wr     (we && aw_off == OFF_FLAG2),
		.clr_data   (w_data_reg[CONV_IRQ_B]),
		.valid_mask (1'b1),
		.en_mask    (wdm_ctl_reg[CONV_IRQ_B]),
		.flags      (conv_flag),
		.masked     (conv_masked)
	);

	// Request reaches the core only under global enable
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_req_reg <= 1'b0;
		end else begin
			irq_req_reg <= gie_reg & ((|masked_flags) | conv_masked[0]);
		end
	end
	assign irq_request = irq_req_reg;

	// Read mux, flags come back gated by their masks
	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = RST_ZERO;
		unique case (ar_off)
			OFF_P5_DIR:  rd_byte = p5_dir_reg;
			OFF_P6_DIR:  rd_byte = p6_dir_reg;
			OFF_P7_DIR:  rd_byte = p7_dir_reg;
			OFF_TA_CTL:  rd_byte = ta_ctl_reg;
			OFF_TBC_CTL: rd_byte = tbc_ctl_reg;
			OFF_MOD_CTL: rd_byte = mod_ctl_reg;
			OFF_PD_CTL:  rd_byte = pd_ctl_reg;
			OFF_OD_CTL:  rd_byte = od_ctl_reg;
			OFF_PU_CTL:  rd_byte = pu_ctl_reg;
			OFF_WDM_CTL: rd_byte = wdm_ctl_reg;
			OFF_IMASK:   rd_byte = imask_reg;
			OFF_FLAG:    rd_byte = masked_flags;
			OFF_FLAG2:   rd_byte = {2'b00, conv_masked[0], 5'b00000};
			OFF_GIE:     rd_byte = {7'h00, gie_reg};
			default:     rd_hit  = 1'b0;
		endcase
	end

	// Read channel
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= RST_ZERO;
			rresp_reg  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_byte;
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Control outputs
	assign port5_dir               = p5_dir_reg;
	assign port6_dir               = p6_dir_reg;
	assign port7_dir               = p7_dir_reg;
	assign timer_a_run             = ta_ctl_reg[TA_RUN_B];
	assign timer_b_run             = tbc_ctl_reg[TB_RUN_B];
	assign timer_b_upper_byte_on   = tbc_ctl_reg[TB_UPPER_B];
	assign timer_c_run             = tbc_ctl_reg[TC_RUN_B];
	assign timer_c_div_log2        = rate_log2(mod_ctl_reg[TC_SCALE_B], mod_ctl_reg[TC_SEL_LO +: 3]);
	assign timer_c_carrier_clocked = mod_ctl_reg[MOD_ON_B] & mod_ctl_reg[MOD_CARR_B];
	assign modulator_on            = mod_ctl_reg[MOD_ON_B];
	assign carrier_mode            = mod_ctl_reg[MOD_CARR_B];
	assign single_pulse_mode       = mod_ctl_reg[MOD_SINGLE_B];
	assign pulldown_n_p5           = pd_ctl_reg[5:0];
	assign pullup_n_p5             = pu_ctl_reg[5:0];
	assign opendrain_n_p6_7        = od_ctl_reg[P67_B];
	assign watchdog_on             = wdm_ctl_reg[WD_ON_B];
	assign watchdog_div_log2       = rate_log2(wdm_ctl_reg[WD_PRE_B], wdm_ctl_reg[WD_SEL_LO +: 3]);
	assign conversion_irq_on       = wdm_ctl_reg[CONV_IRQ_B];

	// Pin value and drive selection
	assign mod_level = mod_ctl_reg[MOD_ON_B] ? modulator_out : 1'b1;
	assign pin_val   = mod_ctl_reg[MOD_PINSEL_B] ? mod_level : port6_pin7_data;
	assign pin_drive = ~p6_dir_reg[P67_B] & (od_ctl_reg[P67_B] | ~pin_val);

	// Registered pin outputs
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_out_reg  <= 1'b1;
			pin_oe_n_reg <= 1'b1;
		end else begin
			pin_out_reg  <= pin_val;
			pin_oe_n_reg <= ~pin_drive;
		end
	end
	assign port6_pin7_out  = pin_out_reg;
	assign port6_pin7_oe_n = pin_oe_n_reg;

	// Pin input synchroniser
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			p67_meta <= 1'b0;
			p67_sync <= 1'b0;
		end else begin
			p67_meta <= port6_pin7_in;
			p67_sync <= p67_meta;
		end
	end
	assign port6_pin7_level = p67_sync;

	// Direction bit set releases the pin
	property p_dir_release;
		@(posedge core_clk) disable iff (!arst_n)
		p6_dir_reg[P67_B] |=> port6_pin7_oe_n;
	endproperty
	a_dir_release: assert property (p_dir_release) else $error("pin driven while floating");

	// Idle modulator holds the routed pin high
	property p_mod_idle;
		@(posedge core_clk) disable iff (!arst_n)
		(!mod_ctl_reg[MOD_ON_B] && mod_ctl_reg[MOD_PINSEL_B]) |=> port6_pin7_out;
	endproperty
	a_mod_idle: assert property (p_mod_idle) else $error("idle modulator pin low");

	// GPIO path when modulator not routed
	property p_gpio_path;
		@(posedge core_clk) disable iff (!arst_n)
		!mod_ctl_reg[MOD_PINSEL_B] |=> port6_pin7_out == $past(port6_pin7_data);
	endproperty
	a_gpio_path: assert property (p_gpio_path) else $error("gpio value not on pin");

	// Open drain never drives high
	property p_open_drain;
		@(posedge core_clk) disable iff (!arst_n)
		(!$past(od_ctl_reg[P67_B]) && port6_pin7_out) |-> port6_pin7_oe_n;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

	// Timer control write lands at the completing edge
	property p_tbc_write;
		@(posedge core_clk) disable iff (!arst_n)
		(we && aw_off == OFF_TBC_CTL) |=> (timer_b_run == $past(w_data_reg[TB_RUN_B]))
			&& (timer_b_upper_byte_on == $past(w_data_reg[TB_UPPER_B]))
			&& (timer_c_run == $past(w_data_reg[TC_RUN_B]));
	endproperty
	a_tbc_write: assert property (p_tbc_write) else $error("timer control write lost");

	// Scale off gives 1:1
	property p_tc_bypass;
		@(posedge core_clk) disable iff (!arst_n)
		!mod_ctl_reg[TC_SCALE_B] |-> timer_c_div_log2 == DIV_BYPASS;
	endproperty
	a_tc_bypass: assert property (p_tc_bypass) else $error("timer C not 1:1");

	// Top code gives 1:256
	property p_tc_max;
		@(posedge core_clk) disable iff (!arst_n)
		(mod_ctl_reg[TC_SCALE_B] && mod_ctl_reg[TC_SEL_LO +: 3] == 3'h7) |-> timer_c_div_log2 == 4'h8;
	endproperty
	a_tc_max: assert property (p_tc_max) else $error("timer C ratio not 1:256");

	// Request needs the global enable
	property p_irq_gate;
		@(posedge core_clk) disable iff (!arst_n)
		irq_request |-> $past(gie_reg) && $past((|masked_flags) || conv_masked[0]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("request without enables");

	// Flag read returns masked flags
	property p_flag_read;
		@(posedge core_clk) disable iff (!arst_n)
		(arvalid && arready && ar_off == OFF_FLAG) |=> rvalid && rdata[7:0] == $past(flags & imask_reg);
	endproperty
	a_flag_read: assert property (p_flag_read) else $error("flag read not masked");

	// Watchdog enable follows its write
	property p_wd_write;
		@(posedge core_clk) disable iff (!arst_n)
		(we && aw_off == OFF_WDM_CTL) |=> watchdog_on == $past(w_data_reg[WD_ON_B]);
	endproperty
	a_wd_write: assert property (p_wd_write) else $error("watchdog enable write lost");
endmodule : peripheral_control_registers

// ===== cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
	// Clock and slave answers
	input  wire logic        core_clk, awready, wready, bvalid, arready, rvalid,
	input  wire logic [1:0]  bresp, rresp,
	input  wire logic [31:0] rdata,
	// Master requests
	output logic [7:0]  awaddr = 0, araddr = 0,
	output logic [31:0] wdata = 0,
	output logic [3:0]  wstrb = 0,
	output logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0
);
	// Write one word, each half dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ad, wd;
		@(posedge core_clk);
		{awaddr, wdata, wstrb} <= {a, d, 4'hF};
		{awvalid, wvalid, bready} <= 3'h7;
		{ad, wd} = 2'h0;
		while (!(ad & wd)) begin
			@(posedge core_clk);
			ad |= awready;
			wd |= wready;
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		do @(posedge core_clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	// Read one word, data taken with the answer
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr <= a;
		{arvalid, rready} <= 2'h3;
		do @(posedge core_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge core_clk); while (!rvalid);
		{d, r} = {rdata, rresp};
		rready <= 1'b0;
	endtask : rd
endmodule : cpu_core_model

// ===== peripheral_control_registers_bench.sv
`timescale 1ns/1ps
module peripheral_control_registers_bench;
	import pcr_pkg::*;
	// Clock, reset, bus and pins
	logic core_clk = 0, arst_n = 0;
	int n_fail, n_compared;
	logic [7:0] awaddr, araddr, port5_dir, port6_dir, port7_dir, irq_events = 0;
	logic [31:0] wdata, rdata, d, q;
	logic [3:0] wstrb, timer_c_div_log2, watchdog_div_log2;
	logic [1:0] bresp, rresp, r;
	logic [5:0] pulldown_n_p5, pullup_n_p5;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic enable_irq_instr = 0, disable_irq_instr = 0, irq_taken = 0, conversion_done_event = 0;
	logic modulator_out = 0, port6_pin7_data = 0, port6_pin7_in = 0, irq_request, timer_a_run;
	logic timer_b_run, timer_b_upper_byte_on, timer_c_run, timer_c_carrier_clocked, modulator_on;
	logic carrier_mode, single_pulse_mode, port6_pin7_out, port6_pin7_oe_n, port6_pin7_level;
	logic opendrain_n_p6_7, watchdog_on, conversion_irq_on;
	// Writable and forced bits per register
	logic [7:0] wm [11] = '{P5_DIR_WMASK, P6_DIR_WMASK, 8'hFF, TA_WMASK, TBC_WMASK, 8'hFF,
		PULL_WMASK, OD_WMASK, PULL_WMASK, WDM_WMASK, IMASK_WMASK};
	logic [7:0] fm [11] = '{0, 0, 0, 0, 0, 0, PULL_FORCE, OD_FORCE, PULL_FORCE, 0, 0};
	peripheral_control_registers peripheral_control_registers_i (.*);
	cpu_core_model cpu_core_model_i (.*);
	always #25 core_clk = ~core_clk;
	// Expected read value and rate code
	function automatic logic [31:0] ex(int i, logic [31:0] v);
		return {24'h0, v[7:0] & wm[i] | fm[i]};
	endfunction : ex
	function automatic logic [3:0] dv(logic [3:0] c);
		return c[3] ? {1'b0, c[2:0]} + 4'h1 : DIV_BYPASS;
	endfunction : dv
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic give_verdict;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	// Hang guard
	initial begin
		#500000;
		n_fail++;
		give_verdict();
	end
	initial begin
		void'($urandom(1758));
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			cpu_core_model_i.rd(8'(4 * i), q, r);
			chk("reset", q, ex(i, 0));
			for (int k = 0; k < 3; k++) begin
				d = k == 0 ? 32'hFF : k == 1 ? 32'h0 : $urandom;
				d = ex(i, d);
				cpu_core_model_i.wr(8'(4 * i), d, r);
				cpu_core_model_i.rd(8'(4 * i), q, r);
				chk("readback", q, ex(i, d));
				if (i < 3) chk("dir", i == 0 ? port5_dir : i == 1 ? port6_dir : port7_dir, d);
				if (i == 3) chk("timer a", timer_a_run, d[2]);
				if (i == 5) chk("mode", {modulator_on, carrier_mode, single_pulse_mode, timer_c_carrier_clocked},
					{d[3:1], d[3] & d[2]});
				if (i == 7) chk("open drain", opendrain_n_p6_7, d[7]);
				if (i == 8) chk("pullup", pullup_n_p5, {d[5], 1'b1, d[3:0]});
				if (i == 4) chk("timers", {timer_b_upper_byte_on, timer_b_run, timer_c_run}, {d[7:6], d[2]});
				if (i == 5) chk("scale", timer_c_div_log2, dv(d[7:4]));
				if (i == 6) chk("pulldown", pulldown_n_p5, {d[5], 1'b1, d[3:0]});
				if (i == 9) chk("wdog", {watchdog_on, conversion_irq_on, watchdog_div_log2}, {d[7], d[5], dv(d[3:0])});
			end
		end
		$display("register test done");
		cpu_core_model_i.wr(OFF_P6_DIR, 32'h00, r);
		cpu_core_model_i.wr(OFF_OD_CTL, 32'h7F, r);
		cpu_core_model_i.wr(OFF_MOD_CTL, 32'h09, r);
		@(posedge core_clk);
		chk("pin mod", {port6_pin7_out, port6_pin7_oe_n}, 2'b00);
		cpu_core_model_i.wr(OFF_MOD_CTL, 32'h01, r);
		@(posedge core_clk);
		chk("pin high", {port6_pin7_out, port6_pin7_oe_n}, 2'b11);
		port6_pin7_in <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("level", port6_pin7_level, 1);
		cpu_core_model_i.wr(OFF_IMASK, 32'h01, r);
		irq_events <= 8'h0D;
		enable_irq_instr <= 1'b1;
		@(posedge core_clk);
		irq_events <= 8'h00;
		enable_irq_instr <= 1'b0;
		cpu_core_model_i.rd(OFF_FLAG, q, r);
		chk("flags", q, 32'h01);
		chk("request", irq_request, 1);
		cpu_core_model_i.rd(OFF_GIE, q, r);
		chk("global on", q, 32'h1);
		cpu_core_model_i.wr(OFF_FLAG, 32'hFF, r);
		cpu_core_model_i.rd(OFF_FLAG, q, r);
		chk("kept", q, 32'h01);
		cpu_core_model_i.wr(OFF_WDM_CTL, 32'h20, r);
		conversion_done_event <= 1'b1;
		@(posedge core_clk);
		conversion_done_event <= 1'b0;
		cpu_core_model_i.rd(OFF_FLAG2, q, r);
		chk("conversion", q, 32'h20);
		irq_taken <= 1'b1;
		@(posedge core_clk);
		irq_taken <= 1'b0;
		cpu_core_model_i.rd(OFF_GIE, q, r);
		chk("taken", q, 32'h0);
		enable_irq_instr <= 1'b1;
		@(posedge core_clk);
		enable_irq_instr <= 1'b0;
		disable_irq_instr <= 1'b1;
		@(posedge core_clk);
		disable_irq_instr <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("masked", irq_request, 0);
		cpu_core_model_i.wr(OFF_FLAG, 32'h00, r);
		cpu_core_model_i.wr(OFF_FLAG2, 32'h00, r);
		cpu_core_model_i.rd(OFF_FLAG, q, r);
		chk("cleared", q, 0);
		cpu_core_model_i.rd(OFF_FLAG2, q, r);
		chk("conv cleared", q, 0);
		cpu_core_model_i.wr(8'h3C, 32'h0, r);
		chk("unmapped", r, RESP_SLVERR);
		cpu_core_model_i.rd(8'h3C, q, r);
		chk("unmapped read", {q[7:0], r}, {8'h00, RESP_SLVERR});
		$display("irq and pin test done");
		give_verdict();
	end
endmodule : peripheral_control_registers_bench
